// [bst_pkg.sv]
package bst_pkg;

    // Instruction register
    localparam int IR_LEN = 3;
    localparam logic [IR_LEN-1:0] INSTR_EXTEST = 3'h0;
    localparam logic [IR_LEN-1:0] INSTR_IDCODE = 3'h1;
    localparam logic [IR_LEN-1:0] INSTR_SAMPLE = 3'h2;
    localparam logic [IR_LEN-1:0] INSTR_CLAMP = 3'h3;
    localparam logic [IR_LEN-1:0] INSTR_HIGHZ = 3'h4;
    localparam logic [IR_LEN-1:0] INSTR_BYPASS = 3'h7;
    localparam logic [IR_LEN-1:0] IR_CAPTURE_VALUE = 3'h1;
    localparam logic [IR_LEN-1:0] IR_RESET_VALUE = INSTR_IDCODE;

    // Identification code layout
    localparam int ID_LEN = 32;
    localparam int ID_MFR_W = 11;
    localparam int ID_PART_W = 16;
    localparam int ID_VER_W = 4;
    localparam logic ID_MARKER = 1'h1;

    // Crossing depth
    localparam int SYNC_STAGES = 2;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } bst_state_e;

    typedef enum logic [1:0] {
        DR_BYPASS, DR_BSR, DR_ID
    } bst_dreg_e;

    typedef struct packed {
        logic drive_bsr;
        logic float_pins;
    } bst_pinmode_s;

    localparam bst_pinmode_s PINMODE_NORMAL = 2'h0;

    function automatic bst_dreg_e bst_dr_select(input logic [IR_LEN-1:0] instr);
        case (instr)
            INSTR_EXTEST, INSTR_SAMPLE: bst_dr_select = DR_BSR;
            INSTR_IDCODE: bst_dr_select = DR_ID;
            default: bst_dr_select = DR_BYPASS;
        endcase
    endfunction

    function automatic bst_pinmode_s bst_pin_mode(input logic [IR_LEN-1:0] instr);
        bst_pin_mode = PINMODE_NORMAL;
        case (instr)
            INSTR_EXTEST, INSTR_CLAMP: bst_pin_mode.drive_bsr = 1'b1;
            INSTR_HIGHZ: bst_pin_mode.float_pins = 1'b1;
            default: bst_pin_mode = PINMODE_NORMAL;
        endcase
    endfunction

endpackage

// [bst_tap.sv]
`timescale 1ns/1ps
`default_nettype none

module bst_tap #(
    parameter int N_IN = 4,
    parameter int N_OUT = 4,
    // Identification fields: arbitrary neutral values
    parameter logic [bst_pkg::ID_VER_W-1:0] ID_VERSION = 4'h1,
    parameter logic [bst_pkg::ID_PART_W-1:0] ID_PART = 16'h00A5,
    parameter logic [bst_pkg::ID_MFR_W-1:0] ID_MFR = 11'h05A
) (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic TEST_CLOCK,
    input wire logic TEST_RESET_N,
    input wire logic TEST_MODE_SELECT,
    input wire logic TEST_SERIAL_IN,
    output logic TEST_SERIAL_OUT,
    output logic TEST_SERIAL_OE,
    input wire logic [N_OUT-1:0] FUNC_OUT,
    input wire logic [N_OUT-1:0] FUNC_OE,
    input wire logic [N_IN-1:0] PIN_IN,
    output logic [N_OUT-1:0] PIN_OUT,
    output logic [N_OUT-1:0] PIN_OE
);
    import bst_pkg::*;

    localparam int BSR_LEN = N_IN + 2 * N_OUT;
    localparam int BSR_OUT_LSB = N_IN;
    localparam int BSR_OE_LSB = N_IN + N_OUT;
    localparam logic [ID_LEN-1:0] ID_CODE = {ID_VERSION, ID_PART, ID_MFR, ID_MARKER};

    // ---------------- Test clock domain ----------------

    // Controller and shift stages
    bst_state_e state;
    bst_state_e next_state;
    logic in_reset;
    logic [IR_LEN-1:0] ir_shift;
    logic [IR_LEN-1:0] ir_latch;
    logic bypass_bit;
    logic [ID_LEN-1:0] id_shift;
    logic [BSR_LEN-1:0] bsr_shift;
    logic [BSR_LEN-1:0] bsr_upd;
    logic upd_toggle;
    logic [SYNC_STAGES-1:0][N_IN-1:0] pin_in_sync;
    logic [SYNC_STAGES-1:0][2*N_OUT-1:0] pin_obs_sync;
    bst_dreg_e dr_sel;
    logic dr_serial;

    // True in the two states that end a scan with an update
    function automatic logic ends_scan(input bst_state_e s);
        return (s == ST_UPD_DR) || (s == ST_UPD_IR);
    endfunction

    // True in the two states that move data through the serial path
    function automatic logic is_shifting(input bst_state_e s);
        return (s == ST_SHIFT_DR) || (s == ST_SHIFT_IR);
    endfunction

    // Next state of the controller
    always_comb begin
        case (state)
            ST_RESET: begin
                next_state = TEST_MODE_SELECT ? ST_RESET : ST_IDLE;
            end
            ST_IDLE: begin
                next_state = TEST_MODE_SELECT ? ST_SEL_DR : ST_IDLE;
            end
            ST_SEL_DR: begin
                next_state = TEST_MODE_SELECT ? ST_SEL_IR : ST_CAP_DR;
            end
            ST_CAP_DR: begin
                next_state = TEST_MODE_SELECT ? ST_EXIT1_DR : ST_SHIFT_DR;
            end
            ST_SHIFT_DR: begin
                next_state = TEST_MODE_SELECT ? ST_EXIT1_DR : ST_SHIFT_DR;
            end
            ST_EXIT1_DR: begin
                next_state = TEST_MODE_SELECT ? ST_UPD_DR : ST_PAUSE_DR;
            end
            ST_PAUSE_DR: begin
                next_state = TEST_MODE_SELECT ? ST_EXIT2_DR : ST_PAUSE_DR;
            end
            ST_EXIT2_DR: begin
                next_state = TEST_MODE_SELECT ? ST_UPD_DR : ST_SHIFT_DR;
            end
            ST_UPD_DR: begin
                next_state = TEST_MODE_SELECT ? ST_SEL_DR : ST_IDLE;
            end
            ST_SEL_IR: begin
                next_state = TEST_MODE_SELECT ? ST_RESET : ST_CAP_IR;
            end
            ST_CAP_IR: begin
                next_state = TEST_MODE_SELECT ? ST_EXIT1_IR : ST_SHIFT_IR;
            end
            ST_SHIFT_IR: begin
                next_state = TEST_MODE_SELECT ? ST_EXIT1_IR : ST_SHIFT_IR;
            end
            ST_EXIT1_IR: begin
                next_state = TEST_MODE_SELECT ? ST_UPD_IR : ST_PAUSE_IR;
            end
            ST_PAUSE_IR: begin
                next_state = TEST_MODE_SELECT ? ST_EXIT2_IR : ST_PAUSE_IR;
            end
            ST_EXIT2_IR: begin
                next_state = TEST_MODE_SELECT ? ST_UPD_IR : ST_SHIFT_IR;
            end
            ST_UPD_IR: begin
                next_state = TEST_MODE_SELECT ? ST_SEL_DR : ST_IDLE;
            end
            default: begin
                next_state = ST_RESET;
            end
        endcase
    end

    // Controller state, forced to reset by the test reset pin
    always_ff @(posedge TEST_CLOCK or negedge TEST_RESET_N) begin
        if (!TEST_RESET_N) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Registered reset flag handed to the core domain
    always_ff @(posedge TEST_CLOCK or negedge TEST_RESET_N) begin
        if (!TEST_RESET_N) begin
            in_reset <= 1'b1;
        end else begin
            in_reset <= (next_state == ST_RESET);
        end
    end

    // Pin levels, synchronised before capture
    always_ff @(posedge TEST_CLOCK) begin
        pin_in_sync[0] <= PIN_IN;
        pin_in_sync[1] <= pin_in_sync[0];
    end

    // Driven outputs, synchronised before capture
    always_ff @(posedge TEST_CLOCK) begin
        pin_obs_sync[0] <= {PIN_OE, PIN_OUT};
        pin_obs_sync[1] <= pin_obs_sync[0];
    end

    // Current instruction decode
    always_comb begin
        dr_sel = bst_dr_select(ir_latch);
    end

    // Instruction shift stage
    always_ff @(posedge TEST_CLOCK or negedge TEST_RESET_N) begin
        if (!TEST_RESET_N) begin
            ir_shift <= IR_CAPTURE_VALUE;
        end else begin
            case (state)
                ST_CAP_IR: ir_shift <= IR_CAPTURE_VALUE;
                ST_SHIFT_IR: ir_shift <= {TEST_SERIAL_IN, ir_shift[IR_LEN-1:1]};
                default: ir_shift <= ir_shift;
            endcase
        end
    end

    // Latched instruction, updated on the falling edge
    always_ff @(negedge TEST_CLOCK or negedge TEST_RESET_N) begin
        if (!TEST_RESET_N) begin
            ir_latch <= IR_RESET_VALUE;
        end else if (state == ST_RESET) begin
            ir_latch <= IR_RESET_VALUE;
        end else if (state == ST_UPD_IR) begin
            ir_latch <= ir_shift;
        end
    end

    // Bypass stage
    always_ff @(posedge TEST_CLOCK or negedge TEST_RESET_N) begin
        if (!TEST_RESET_N) begin
            bypass_bit <= 1'b0;
        end else if (dr_sel == DR_BYPASS) begin
            case (state)
                ST_CAP_DR: bypass_bit <= 1'b0;
                ST_SHIFT_DR: bypass_bit <= TEST_SERIAL_IN;
                default: bypass_bit <= bypass_bit;
            endcase
        end
    end

    // Identification shift stage
    always_ff @(posedge TEST_CLOCK or negedge TEST_RESET_N) begin
        if (!TEST_RESET_N) begin
            id_shift <= ID_CODE;
        end else if (dr_sel == DR_ID) begin
            case (state)
                ST_CAP_DR: id_shift <= ID_CODE;
                ST_SHIFT_DR: id_shift <= {TEST_SERIAL_IN, id_shift[ID_LEN-1:1]};
                default: id_shift <= id_shift;
            endcase
        end
    end

    // Boundary scan shift stage: inputs low, then output data, then enables
    always_ff @(posedge TEST_CLOCK or negedge TEST_RESET_N) begin
        if (!TEST_RESET_N) begin
            bsr_shift <= '0;
        end else if (dr_sel == DR_BSR) begin
            case (state)
                ST_CAP_DR: bsr_shift <= {pin_obs_sync[1], pin_in_sync[1]};
                ST_SHIFT_DR: bsr_shift <= {TEST_SERIAL_IN, bsr_shift[BSR_LEN-1:1]};
                default: bsr_shift <= bsr_shift;
            endcase
        end
    end

    // Boundary output latches, changed only on the falling edge in Update-DR
    always_ff @(negedge TEST_CLOCK or negedge TEST_RESET_N) begin
        if (!TEST_RESET_N) begin
            bsr_upd <= '0;
        end else if (state == ST_UPD_DR && dr_sel == DR_BSR) begin
            bsr_upd <= bsr_shift;
        end
    end

    // Event toggle: every update announces fresh mode and latch data
    always_ff @(negedge TEST_CLOCK or negedge TEST_RESET_N) begin
        if (!TEST_RESET_N) begin
            upd_toggle <= 1'b0;
        end else if (ends_scan(state)) begin
            upd_toggle <= ~upd_toggle;
        end
    end

    // Serial output selection
    always_comb begin
        case (dr_sel)
            DR_BSR: dr_serial = bsr_shift[0];
            DR_ID: dr_serial = id_shift[0];
            default: dr_serial = bypass_bit;
        endcase
    end

    // Serial output enable, high only in Shift-DR and Shift-IR
    always_ff @(negedge TEST_CLOCK or negedge TEST_RESET_N) begin
        if (!TEST_RESET_N) begin
            TEST_SERIAL_OE <= 1'b0;
        end else begin
            TEST_SERIAL_OE <= is_shifting(state);
        end
    end

    // Serial output data, changed on the falling edge
    always_ff @(negedge TEST_CLOCK or negedge TEST_RESET_N) begin
        if (!TEST_RESET_N) begin
            TEST_SERIAL_OUT <= 1'b0;
        end else begin
            TEST_SERIAL_OUT <= (state == ST_SHIFT_IR) ? ir_shift[0] : dr_serial;
        end
    end

    // ---------------- Core clock domain ----------------

    // Crossing and pin drive state
    logic [SYNC_STAGES-1:0] toggle_sync;
    logic toggle_seen;
    logic [SYNC_STAGES-1:0] reset_sync;
    bst_pinmode_s pin_mode;
    logic [N_OUT-1:0] hold_out;
    logic [N_OUT-1:0] hold_oe;
    logic [N_OUT-1:0] next_pin_out;
    logic [N_OUT-1:0] next_pin_oe;

    // Crossing of the update toggle
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            toggle_sync <= '0;
            toggle_seen <= 1'b0;
        end else begin
            toggle_sync <= {toggle_sync[0], upd_toggle};
            toggle_seen <= toggle_sync[1];
        end
    end

    // Crossing of the reset flag
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            reset_sync <= '1;
        end else begin
            reset_sync <= {reset_sync[0], in_reset};
        end
    end

    // Mode snapshot, taken when the toggle has settled
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            pin_mode <= PINMODE_NORMAL;
        end else if (reset_sync[1]) begin
            pin_mode <= PINMODE_NORMAL;
        end else if (toggle_sync[1] != toggle_seen) begin
            pin_mode <= bst_pin_mode(ir_latch);
        end
    end

    // Boundary latch snapshot, taken with the mode
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            hold_out <= '0;
            hold_oe <= '0;
        end else if (!reset_sync[1] && toggle_sync[1] != toggle_seen) begin
            hold_out <= bsr_upd[BSR_OUT_LSB +: N_OUT];
            hold_oe <= bsr_upd[BSR_OE_LSB +: N_OUT];
        end
    end

    // Pin drive selection
    always_comb begin
        if (pin_mode.float_pins) begin
            next_pin_out = '0;
            next_pin_oe = '0;
        end else if (pin_mode.drive_bsr) begin
            next_pin_out = hold_out;
            next_pin_oe = hold_oe;
        end else begin
            next_pin_out = FUNC_OUT;
            next_pin_oe = FUNC_OE;
        end
    end

    // Registered pin drive
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            PIN_OUT <= '0;
            PIN_OE <= '0;
        end else begin
            PIN_OUT <= next_pin_out;
            PIN_OE <= next_pin_oe;
        end
    end

endmodule

`default_nettype wire

// [bst_tap_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module bst_tap_checker
    import bst_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic TEST_CLOCK,
    input wire logic TEST_RESET_N,
    input wire logic TEST_MODE_SELECT,
    input wire logic TEST_SERIAL_OUT,
    input wire logic TEST_SERIAL_OE
);
    // Five highs land in reset from anywhere
    sequence s_tlr;
        TEST_MODE_SELECT [*5];
    endsequence
    sequence s_shift_ir;
        s_tlr ##1 !TEST_MODE_SELECT ##1 TEST_MODE_SELECT [*2] ##1 !TEST_MODE_SELECT [*2];
    endsequence
    sequence s_shift_dr;
        s_tlr ##1 !TEST_MODE_SELECT ##1 TEST_MODE_SELECT ##1 !TEST_MODE_SELECT [*2];
    endsequence
    AST_TLR_QUIET: assert property (@(posedge TEST_CLOCK) disable iff (!TEST_RESET_N)
        s_tlr |=> !TEST_SERIAL_OE) else $error("serial out driven in reset state");
    AST_IR_OE: assert property (@(posedge TEST_CLOCK) disable iff (!TEST_RESET_N)
        s_shift_ir |=> TEST_SERIAL_OE) else $error("no drive in instruction shift");
    AST_IR_CAPT: assert property (@(posedge TEST_CLOCK) disable iff (!TEST_RESET_N)
        s_shift_ir |=> TEST_SERIAL_OUT == IR_CAPTURE_VALUE[0]) else $error("bad ir capture");
    AST_DR_OE: assert property (@(posedge TEST_CLOCK) disable iff (!TEST_RESET_N)
        s_shift_dr |=> TEST_SERIAL_OE) else $error("no drive in data shift");
    AST_ID_LSB: assert property (@(posedge TEST_CLOCK) disable iff (!TEST_RESET_N)
        s_shift_dr |=> TEST_SERIAL_OUT == ID_MARKER) else $error("id lsb wrong");
    AST_SHIFT_STAY: assert property (@(posedge TEST_CLOCK) disable iff (!TEST_RESET_N)
        TEST_SERIAL_OE && !TEST_MODE_SELECT |=> TEST_SERIAL_OE) else $error("left shift");
    AST_SHIFT_EXIT: assert property (@(posedge TEST_CLOCK) disable iff (!TEST_RESET_N)
        TEST_SERIAL_OE && TEST_MODE_SELECT |=> !TEST_SERIAL_OE) else $error("drive kept");
    AST_OE_FALL: assert property (@(posedge CORE_CLK) disable iff (RESET || !TEST_RESET_N)
        TEST_CLOCK && $past(TEST_CLOCK) |-> $stable(TEST_SERIAL_OE)) else $error("oe moved");
    AST_OUT_FALL: assert property (@(posedge CORE_CLK) disable iff (RESET || !TEST_RESET_N)
        TEST_CLOCK && $past(TEST_CLOCK) |-> $stable(TEST_SERIAL_OUT)) else $error("out moved");
endmodule
bind bst_tap bst_tap_checker u_chk (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .TEST_CLOCK(TEST_CLOCK),
    .TEST_RESET_N(TEST_RESET_N), .TEST_MODE_SELECT(TEST_MODE_SELECT),
    .TEST_SERIAL_OUT(TEST_SERIAL_OUT), .TEST_SERIAL_OE(TEST_SERIAL_OE)
);
`default_nettype wire

// [bst_tester.sv]
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
    output logic test_clock,
    output logic test_reset_n,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    initial begin
        test_clock = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        test_reset_n = 1'b0;
        #103 test_reset_n = 1'b1;
    end
    // One test clock, stopped low between calls; serial out read at the rise
    task automatic bit_cycle(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #80 test_clock = 1'b1;
        q = tdo_oe ? tdo : 1'bx;
        #80 test_clock = 1'b0;
    endtask
    task automatic goto_reset();
        logic q;
        repeat (5) bit_cycle(1'b1, 1'b0, q);
        bit_cycle(1'b0, 1'b0, q);
    endtask
    task automatic trst_pulse();
        logic q;
        test_reset_n = 1'b0;
        #100 test_reset_n = 1'b1;
        bit_cycle(1'b0, 1'b0, q);
    endtask
    // From idle: scan n bits LSB first, optional pause before update
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        input logic pause, output logic [31:0] dout);
        logic q;
        dout = '0;
        bit_cycle(1'b1, 1'b0, q);
        if (ir) bit_cycle(1'b1, 1'b0, q);
        bit_cycle(1'b0, 1'b0, q);
        bit_cycle(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            bit_cycle(i == n - 1, din[i], q);
            dout[i] = q;
        end
        if (pause) begin
            bit_cycle(1'b0, 1'b0, q);
            bit_cycle(1'b0, 1'b0, q);
            bit_cycle(1'b1, 1'b0, q);
        end
        bit_cycle(1'b1, 1'b0, q);
        bit_cycle(1'b0, 1'b0, q);
    endtask
endmodule
`default_nettype wire

// [bst_tap_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module bst_tap_bench;
    import bst_pkg::*;
    localparam logic [31:0] ID_EXP = {4'h1, 16'h00A5, 11'h05A, ID_MARKER};
    localparam logic [31:0] PAT = 32'hA5C3_0F96;
    localparam logic [2:0] CODES [7] = '{INSTR_IDCODE, INSTR_SAMPLE, INSTR_EXTEST,
        INSTR_CLAMP, INSTR_HIGHZ, INSTR_BYPASS, 3'h5};
    logic core_clk, rst, tck, trst_n, tms, tdi, tdo, tdo_oe;
    logic [3:0] func_out, func_oe, pin_in, pin_out, pin_oe;
    int err_total = 0;
    int compares = 0;
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    bst_tester u_tst (.test_clock(tck), .test_reset_n(trst_n), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe));
    bst_tap #(.ID_VERSION(4'h1), .ID_PART(16'h00A5), .ID_MFR(11'h05A)) DUT (
        .CORE_CLK(core_clk), .RESET(rst), .TEST_CLOCK(tck), .TEST_RESET_N(trst_n),
        .TEST_MODE_SELECT(tms), .TEST_SERIAL_IN(tdi), .TEST_SERIAL_OUT(tdo),
        .TEST_SERIAL_OE(tdo_oe), .FUNC_OUT(func_out), .FUNC_OE(func_oe), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE(pin_oe));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wait_pins(input logic [7:0] exp);
        repeat (6) @(posedge core_clk);
        #1 check("pins", 32'(exp), 32'({pin_oe, pin_out}));
    endtask
    task automatic t_bypass();
        logic [31:0] q;
        u_tst.goto_reset();
        u_tst.scan(1'b1, 3, 32'(INSTR_BYPASS), 1'b1, q);
        check("ir capture", 32'(IR_CAPTURE_VALUE), q);
        u_tst.scan(1'b0, 8, 32'h0000_00B5, 1'b0, q);
        check("bypass", 32'h0000_006A, q);
        wait_pins({func_oe, func_out});
    endtask
    task automatic t_codes();
        logic [31:0] q;
        logic [7:0] pins;
        logic [11:0] cap;
        int len;
        for (int k = 0; k < 7; k++) begin
            @(posedge core_clk);
            #1 func_out = 4'(k + 1);
            u_tst.scan(1'b1, 3, 32'(CODES[k]), 1'b0, q);
            len = (CODES[k] == INSTR_IDCODE) ? 32 : 1;
            pins = {func_oe, func_out};
            cap = {func_oe, func_out, pin_in};
            if (CODES[k] == INSTR_SAMPLE || CODES[k] == INSTR_EXTEST) len = 12;
            if (CODES[k] == INSTR_EXTEST || CODES[k] == INSTR_CLAMP) pins = PAT[31:24];
            if (CODES[k] == INSTR_EXTEST) cap = {PAT[31:24], pin_in};
            if (CODES[k] == INSTR_HIGHZ) pins = 8'h00;
            u_tst.scan(1'b0, 32, PAT, 1'b0, q);
            if (len == 32) check("id", ID_EXP, q);
            if (len < 32) check("path", PAT & ~(32'hFFFF_FFFF << (32 - len)), q >> len);
            if (len == 12) check("capture", 32'(cap), 32'(q[11:0]));
            wait_pins(pins);
        end
    endtask
    task automatic t_resets();
        logic [31:0] q;
        u_tst.scan(1'b1, 3, 32'(INSTR_EXTEST), 1'b0, q);
        u_tst.trst_pulse();
        wait_pins({func_oe, func_out});
        u_tst.scan(1'b0, 32, 32'h0, 1'b0, q);
        check("id after test reset", ID_EXP, q);
        @(posedge core_clk);
        #1 rst = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 check("pins in reset", 32'h0, 32'({pin_oe, pin_out}));
        rst = 1'b0;
        wait_pins({func_oe, func_out});
    endtask
    initial begin
        #500000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        logic [31:0] q;
        rst = 1'b1;
        func_out = 4'h3;
        func_oe = 4'hC;
        pin_in = 4'h9;
        repeat (12) @(posedge core_clk);
        #1 rst = 1'b0;
        u_tst.goto_reset();
        u_tst.scan(1'b0, 32, 32'h0, 1'b0, q);
        check("id at power-up", ID_EXP, q);
        t_bypass();
        t_codes();
        t_resets();
        tally_and_finish();
    end
endmodule
`default_nettype wire
